// ### shared/deser_pkg.sv
`default_nettype none
package deser_pkg;
   localparam int WORD_W = 4;
   localparam int DIV_A = 4;
   localparam int DIV_B = 8;
   localparam int CNT_W = 3;
   localparam logic [2:0] CNT_LAST_4 = 3'h3;
   localparam logic [2:0] CNT_LAST_8 = 3'h7;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] DIV4_HALF = 3'h2;
   localparam logic [2:0] DIV8_HALF = 3'h4;
   localparam logic [1:0] SLIP_MIN_CYC = 2'h2;
   typedef enum logic {SLIP_IDLE, SLIP_HELD} slip_state_t;
   typedef struct packed {
      logic data;
      logic select_a;
      logic slip;
      logic wide_mode;
   } pin_bundle_t;
endpackage
`default_nettype wire

// ### src/pin_sync.sv
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   // Two flops per bit; first stage is read only by the second
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= async_in;
         stage2_r <= stage1_r;
      end
   end

   assign sync_out = stage2_r;
endmodule
`default_nettype wire

// ### src/serial_to_parallel_4bit_deserializer.sv
// Contract
// R1 - Four serial bits form a word; first received bit lands on bit 0.
// R2 - Produce divide-by-4 and divide-by-8 clocks from the bit clock.
// R3 - Select high takes input A, low takes input B.
// R4 - Each qualifying slip pulse moves the word boundary by one bit.
// R5 - Slip pulse may be asynchronous but must last two clock periods.
// R6 - Several bits of shift need several pulses; one bit per pulse.
// R7 - Width input low or open gives 4-bit conversion; the code has no pull-down on the pin, so only a driven low does.
// R8 - Width input high updates outputs once per eight cycles.
// R9 - Serial stream is NRZ, one bit per clock period.
// R10 - In 4-bit mode outputs update every four cycles with div-4 edge.
// R11 - Serial output repeats the selected input after registering.
`default_nettype none
module serial_to_parallel_4bit_deserializer #(
   parameter int WORD_W = deser_pkg::WORD_W
) (
   input wire logic REF_CLK_IN,
   input wire logic RESET_IN,
   input wire logic SERIAL_IN_A_IN,
   input wire logic SERIAL_IN_B_IN,
   input wire logic SELECT_A_IN,
   input wire logic BIT_SLIP_IN,
   input wire logic WIDE_MODE_IN,
   output logic [WORD_W-1:0] PARALLEL_WORD_OUT,
   output logic CLOCK_DIV4_OUT,
   output logic CLOCK_DIV8_OUT,
   output logic SERIAL_OUT_PASS_OUT
);
   deser_pkg::pin_bundle_t pins_raw;
   deser_pkg::pin_bundle_t pins;
   logic serial_bit;
   logic [WORD_W-1:0] shift_r, shift_nxt;
   logic [WORD_W-1:0] word_r, word_nxt;
   logic [deser_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
   logic div4_r, div4_nxt, div8_r, div8_nxt;
   logic pass_r, pass_nxt;
   deser_pkg::slip_state_t slip_st_r, slip_st_nxt;
   logic [1:0] slip_len_r, slip_len_nxt;
   logic slip_go;
   logic word_last;

   // Pins are asynchronous to the clock; all pass two flops
   assign pins_raw.data = SELECT_A_IN ? SERIAL_IN_A_IN : SERIAL_IN_B_IN; // [R3]
   assign pins_raw.select_a = SELECT_A_IN;
   assign pins_raw.slip = BIT_SLIP_IN;
   assign pins_raw.wide_mode = WIDE_MODE_IN;

   pin_sync #(.WIDTH($bits(deser_pkg::pin_bundle_t))) u_sync (
      .clk_in(REF_CLK_IN),
      .rst_in(RESET_IN),
      .async_in(pins_raw),
      .sync_out(pins)
   );

   // NRZ: one sample per clock is one bit
   assign serial_bit = pins.data; // [R9]

   // Slip qualifier: pulse must stand two cycles, fires once per pulse
   always_comb begin
      slip_st_nxt = slip_st_r;
      slip_len_nxt = slip_len_r;
      slip_go = 1'b0;
      case (slip_st_r)
         deser_pkg::SLIP_IDLE: begin
            if (pins.slip) begin
               if (slip_len_r == deser_pkg::SLIP_MIN_CYC - 2'h1) begin
                  slip_go = 1'b1; // [R5] [R6]
                  slip_st_nxt = deser_pkg::SLIP_HELD;
                  slip_len_nxt = 2'h0;
               end else begin
                  slip_len_nxt = slip_len_r + 2'h1;
               end
            end else begin
               slip_len_nxt = 2'h0;
            end
         end
         deser_pkg::SLIP_HELD: begin
            // Wait for release so a long pulse still counts once
            if (!pins.slip) begin
               slip_st_nxt = deser_pkg::SLIP_IDLE;
            end
         end
         default: begin
            slip_st_nxt = deser_pkg::SLIP_IDLE;
            slip_len_nxt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         slip_st_r <= deser_pkg::SLIP_IDLE;
         slip_len_r <= 2'h0;
      end else begin
         slip_st_r <= slip_st_nxt;
         slip_len_r <= slip_len_nxt;
      end
   end

   // End of word depends on mode; a driven low pin means 4-bit, and nothing pulls an open pin low
   assign word_last = pins.wide_mode ? (cnt_r == deser_pkg::CNT_LAST_8) // [R8]
                                     : (cnt_r[1:0] == deser_pkg::CNT_LAST_4[1:0]); // [R7]

   // Bit counter, shifter, dividers; slip holds the counter one cycle
   always_comb begin
      shift_nxt = {serial_bit, shift_r[WORD_W-1:1]}; // [R1]
      word_nxt = word_r;
      pass_nxt = serial_bit; // [R11]
      if (slip_go) begin
         cnt_nxt = cnt_r; // [R4]
      end else begin
         cnt_nxt = cnt_r + deser_pkg::CNT_ONE; // [R2]
      end
      if (word_last && !slip_go) begin
         word_nxt = shift_nxt; // [R1] [R10]
      end
      div4_nxt = (cnt_nxt[1:0] < deser_pkg::DIV4_HALF[1:0]); // [R2]
      div8_nxt = (cnt_nxt < deser_pkg::DIV8_HALF); // [R2]
   end

   always_ff @(posedge REF_CLK_IN or posedge RESET_IN) begin
      if (RESET_IN) begin
         shift_r <= '0;
         word_r <= '0;
         cnt_r <= deser_pkg::CNT_ZERO;
         // Dividers start at their zero-count level so the first period is whole
         div4_r <= (deser_pkg::CNT_ZERO[1:0] < deser_pkg::DIV4_HALF[1:0]); // [R2]
         div8_r <= (deser_pkg::CNT_ZERO < deser_pkg::DIV8_HALF); // [R2]
         pass_r <= 1'b0;
      end else begin
         shift_r <= shift_nxt;
         word_r <= word_nxt;
         cnt_r <= cnt_nxt;
         div4_r <= div4_nxt;
         div8_r <= div8_nxt;
         pass_r <= pass_nxt;
      end
   end

   assign PARALLEL_WORD_OUT = word_r;
   assign CLOCK_DIV4_OUT = div4_r;
   assign CLOCK_DIV8_OUT = div8_r;
   assign SERIAL_OUT_PASS_OUT = pass_r;

   // Named steps: slip-free divider periods, and a fresh slip strobe held two cycles
   sequence div4_quiet_period;
      ($rose(CLOCK_DIV4_OUT) && !slip_go) ##1 !slip_go [*3];
   endsequence

   sequence div8_quiet_period;
      ($rose(CLOCK_DIV8_OUT) && !slip_go) ##1 !slip_go [*7];
   endsequence

   sequence slip_fresh_hold;
      (slip_st_r == deser_pkg::SLIP_IDLE && !pins.slip) ##1 pins.slip [*2];
   endsequence

   // Pass-through is the synced bit one flop later
   chk_pass_repeat: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R11]
      SERIAL_OUT_PASS_OUT == $past(serial_bit))
      else $error("pass data wrong");

   // A period with no slip in it is exactly four or eight clocks
   chk_div4_period: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R2]
      div4_quiet_period |=> $rose(CLOCK_DIV4_OUT))
      else $error("div4 period wrong");

   chk_div8_period: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R2]
      div8_quiet_period |=> $rose(CLOCK_DIV8_OUT))
      else $error("div8 period wrong");

   // Word changes only on the divider edges
   chk_word_hold4: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R10]
      $changed(PARALLEL_WORD_OUT) && !pins.wide_mode |-> $rose(CLOCK_DIV4_OUT))
      else $error("word not on div4 edge");

   chk_word_hold8: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R8]
      $changed(PARALLEL_WORD_OUT) && $past(pins.wide_mode) |-> $rose(CLOCK_DIV8_OUT))
      else $error("wide word off div8 edge");

   // Slip qualifier: taken once, only after two synced high cycles
   chk_slip_once: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R6]
      slip_go |=> !slip_go)
      else $error("slip fired twice");

   chk_slip_held: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R5]
      slip_go |-> pins.slip && $past(pins.slip))
      else $error("short slip taken");

   chk_slip_taken: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R4]
      slip_fresh_hold |-> slip_go)
      else $error("held slip not taken");

   chk_slip_stall: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R4]
      slip_go |=> cnt_r == $past(cnt_r))
      else $error("slip did not stall");

   // Word contents at each 4-bit load; chk_mode_four checks only the load where cnt_r is 3
   chk_bit_order: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R1]
      word_last && !slip_go && !pins.wide_mode |=>
      PARALLEL_WORD_OUT[0] == $past(shift_r[1]) &&
      PARALLEL_WORD_OUT[WORD_W-1] == $past(serial_bit))
      else $error("bit order wrong");

   chk_mode_four: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN) // [R7]
      !pins.wide_mode && cnt_r == deser_pkg::CNT_LAST_4 && !slip_go |=>
      PARALLEL_WORD_OUT == $past(shift_nxt))
      else $error("4-bit update missed");
endmodule
`default_nettype wire

// ### sim/serial_source.sv
`default_nettype none
module serial_source (
   input wire logic clk_in,
   input wire logic pattern_in,
   output logic line_a_out,
   output logic line_b_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Cyclic word whose eight 4-bit windows all differ, so the bench can find the lag
   logic [7:0] pat_r = 8'h1d;
   initial begin
      line_a_out = 1'h0;
      line_b_out = 1'h0;
   end
   // NRZ, one fresh bit per clock period, launched off the sampling edge
   always @(negedge clk_in) begin
      pat_r = {pat_r[6:0], pat_r[7]};
      line_a_out = pattern_in ? pat_r[7] : 1'($urandom);
      line_b_out = pattern_in ? ~pat_r[7] : 1'($urandom);
   end
endmodule
`default_nettype wire

// ### sim/serial_to_parallel_4bit_deserializer_test.sv
`default_nettype none
module serial_to_parallel_4bit_deserializer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0, rst = 1'h1, a, b, sel = 1'h1, slip = 1'h0, wide = 1'h0, pat = 1'h1;
   logic d4, d8, so, q4 = 1'h0, q8 = 1'h0;
   logic [3:0] word;
   logic [23:0] h = 24'h00_0000;
   logic [7:0] o = 8'h00;
   int miscompares = 0, cmp_count = 0, sl = -1, wl = -1, k4 = 0, k8 = 0, sp = 0, len;
   bit chk = 0, ok;
   serial_source src (.clk_in(clk), .pattern_in(pat), .line_a_out(a), .line_b_out(b));
   serial_to_parallel_4bit_deserializer DUT (.REF_CLK_IN(clk), .RESET_IN(rst),
      .SERIAL_IN_A_IN(a), .SERIAL_IN_B_IN(b), .SELECT_A_IN(sel), .BIT_SLIP_IN(slip),
      .WIDE_MODE_IN(wide), .PARALLEL_WORD_OUT(word), .CLOCK_DIV4_OUT(d4),
      .CLOCK_DIV8_OUT(d8), .SERIAL_OUT_PASS_OUT(so));
   initial forever #12.5 clk = ~clk;
   task automatic check(input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Word as it would hold the four bits ending l samples back, oldest on bit 0
   function automatic logic [3:0] nib(int l);
      return {h[l], h[l+1], h[l+2], h[l+3]};
   endfunction
   // Reference history of the selected line, newest in bit 0
   always @(posedge clk) h <= {h[22:0], sel ? a : b};
   // Divider periods, pass-through lag and word contents; a slip stretches one period
   always @(negedge clk) begin
      o = {o[6:0], so};
      k4++;
      k8++;
      if (d4 && !q4) begin
         if (chk) check(4'(k4 == 5 ? 4 : k4), 4'h4);
         if (k4 == 5) sp++;
         k4 = 0;
      end
      if (d8 && !q8) begin
         if (chk) check(4'(k8 == 9 ? 8 : k8), 4'h8);
         k8 = 0;
      end
      q4 = d4;
      q8 = d8;
      if (chk) begin
         check({3'h0, so}, {3'h0, h[sl]});
         check(word, nib(wl + (wide ? k8 : k4)));
      end
   end
   initial begin
      #50000;
      miscompares++;
      stop_test;
   end
   initial begin
      void'($urandom(5935));
      repeat (8) @(negedge clk);
      rst = 1'h0;
      repeat (40) @(negedge clk);
      do begin @(negedge clk); #1; end while (k4 != 0);
      // Lags found once on the known pattern, then held for the whole run
      for (int s = 0; s < 8; s++) begin
         ok = 1;
         for (int i = 0; i < 8; i++) ok &= (o[i] === h[s+i]);
         if (ok) sl = s;
         if (word === nib(s)) wl = s;
      end
      if (sl < 0 || wl < 0) miscompares++;
      chk = 1;
      pat = 1'h0;
      repeat (60) @(negedge clk) sel = 1'($urandom);
      // Slips of 2..4 cycles count once each; the single-cycle one is ignored
      sp = 0;
      for (int n = 0; n < 7; n++) begin
         len = (n == 3) ? 1 : 2 + $urandom % 3;
         slip = 1'h1;
         repeat (len) @(negedge clk);
         slip = 1'h0;
         repeat (10) @(negedge clk) sel = 1'($urandom);
      end
      check(4'(sp), 4'h6);
      for (int m = 1; m >= 0; m--) begin
         chk = 0;
         wide = 1'(m);
         repeat (20) @(negedge clk);
         chk = 1;
         repeat (80) @(negedge clk) sel = 1'($urandom);
      end
      stop_test;
   end
endmodule
`default_nettype wire
